/* dv/cfg_loader_checker.sv */
// port-level assertions for the configuration and flash loader
`timescale 1ns/1ps
module cfg_loader_checker
  import cfg_loader_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  input wire logic [cfg_loader_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic TGT_PROG_B_O,
  input wire logic TGT_INIT_B_I,
  input wire logic TGT_DONE_I,
  input wire logic TGT_MODE_PS_O,
  input wire logic [7:0] TGT_D_O,
  input wire logic TGT_CS_B_O,
  input wire logic TGT_CCLK_O,
  input wire logic DONE_LED_O,
  input wire logic FL_SEL_CTRL_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  wire ctl_wr = WR_I && ADDR_I == OFS_TGT_CTRL;
  wire ctl_rd = RD_I && ADDR_I == OFS_TGT_CTRL;
  wire ps_wr = WR_I && ADDR_I == OFS_PS_DATA;

  AST_HOLD_PIN: assert property (
    ctl_wr |=> TGT_PROG_B_O == !$past(WDATA_I[BIT_HOLD]))
    else $error("program pin does not follow hold bit");
  AST_MODE_PIN: assert property (
    ctl_wr |=> TGT_MODE_PS_O == $past(WDATA_I[BIT_MODE]))
    else $error("mode pin does not follow mode bit");
  // pins must be steady a few cycles, the read may pass a synchroniser
  AST_INIT_READ: assert property (
    $stable(TGT_INIT_B_I) [*4] ##0 ctl_rd |=> RDATA_O[BIT_INIT] == $past(TGT_INIT_B_I))
    else $error("init level misread");
  AST_DONE_READ: assert property (
    $stable(TGT_DONE_I) [*4] ##0 ctl_rd |=> RDATA_O[BIT_DONE] == $past(TGT_DONE_I))
    else $error("done flag misread");
  AST_DONE_LED: assert property (
    $past(RST_B_I) |-> DONE_LED_O == $past(TGT_DONE_I))
    else $error("done indicator wrong");
  AST_PS_BYTE: assert property (
    ps_wr && TGT_MODE_PS_O && TGT_CS_B_O |=>
    (TGT_D_O == $past(WDATA_I[7:0]) && !TGT_CS_B_O && !TGT_CCLK_O) ##1
    (TGT_CCLK_O && !TGT_CS_B_O) ##1 (TGT_CS_B_O && !TGT_CCLK_O))
    else $error("parallel byte transfer wrong");
  AST_CCLK_CAUSE: assert property (
    $rose(TGT_CCLK_O) |-> $past(ps_wr, 2))
    else $error("configuration clock without data write");
  AST_ACC_SEL: assert property (
    WR_I && ADDR_I == OFS_ACC_EN |=> FL_SEL_CTRL_O == $past(WDATA_I[BIT_ACC_EN]))
    else $error("flash ownership does not follow enable");

  cover property ($rose(TGT_CCLK_O));
  cover property ($rose(DONE_LED_O));
  cover property ($fell(FL_SEL_CTRL_O));
endmodule : cfg_loader_checker

/* dv/cfg_loader_tb.sv */
// self-checking bench for the configuration and flash loader
`timescale 1ns/1ps
module cfg_loader_tb;
  import cfg_loader_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic init_b = 1'b0;
  logic done = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata, got;
  logic prog_b, mode_ps, d_oe, cs_b, cclk, led, sck, fcs_b, mosi, miso, sel;
  logic [7:0] tdata, first_b;
  logic [7:0] seen[$];
  logic [7:0] stream[5] = '{8'h00, 8'hff, 8'h5a, 8'hc3, 8'h11}; // clock options ride inside a real stream
  logic [7:0] erase_ops[2] = '{OP_CHIP_ERASE, OP_SECT_ERASE};
  int prog_bits, err_count = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  cfg_loader u_cfg_loader (.CORE_CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .TGT_PROG_B_O(prog_b), .TGT_INIT_B_I(init_b), .TGT_DONE_I(done),
    .TGT_MODE_PS_O(mode_ps), .TGT_D_O(tdata), .TGT_D_OE_O(d_oe), .TGT_CS_B_O(cs_b), .TGT_CCLK_O(cclk),
    .DONE_LED_O(led), .FL_SCK_O(sck), .FL_CS_B_O(fcs_b), .FL_MOSI_O(mosi), .FL_MISO_I(miso),
    .FL_SEL_CTRL_O(sel));
  flash_model u_flash_model (.sck_i(sck), .cs_b_i(fcs_b), .mosi_i(mosi), .miso_o(miso),
    .prog_first_o(first_b), .prog_bits_o(prog_bits));
  always @(posedge clk)
    if (cclk && !cs_b)
      seen.push_back(tdata);
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] k, input logic [31:0] e, input string m);
    rd_reg(a, got);
    chk(got & k, e, m);
  endtask : rdc
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      rd_reg(OFS_FL_STAT, got);
      n++;
    end while ((got & 32'h3) !== 32'h0 && n < 20000);
    chk(32'(n < 20000), 32'h1, "instruction never finished");
  endtask : wait_idle
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial
  begin
    #2000000;
    err_count++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    wr_reg(OFS_ACC_EN, 32'h1);
    chk(sel, 1, "flash owned by controller");
    wr_reg(OFS_TGT_CTRL, 32'h3); // hold the target and select parallel slave mode in one write
    chk({prog_b, mode_ps, d_oe}, 3'b011, "held in parallel mode");
    rdc(OFS_TGT_CTRL, 32'h300, 32'h0, "init low while held");
    wr_reg(OFS_TGT_CTRL, 32'h2);
    chk(prog_b, 1, "target released");
    @(posedge clk);
    init_b <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(OFS_TGT_CTRL, 32'h300, 32'h100, "init high");
    // a write two cycles after the last byte must be dropped
    foreach (stream[i])
    begin
      wr_reg(OFS_PS_DATA, {24'h0, stream[i]});
      if (i == 4)
        wr_reg(OFS_PS_DATA, 32'h22);
      @(posedge clk);
    end
    done <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(OFS_TGT_CTRL, 32'h300, 32'h300, "done flag");
    chk(led, 1, "done indicator");
    chk(seen.size(), 5, "clock pulse count");
    foreach (stream[i])
      chk(seen[i], stream[i], "byte on data pins");
    wr_reg(OFS_TGT_CTRL, 32'h1);
    chk(d_oe, 0, "data pins released in flash mode");
    wr_reg(OFS_PS_DATA, 32'h77);
    repeat (4) @(posedge clk);
    chk(seen.size(), 5, "no clock in flash mode");
    $display("parallel load test done");
    for (int i = 0; i < PAGE_BYTES; i++)
      wr_reg(OFS_DATA_BASE + 12'(4 * i), 32'(i) ^ 32'h3c);
    wr_reg(OFS_INS_CFG, {OP_PROG, 24'h000100});
    wr_reg(OFS_INS_CMD, 32'h1);
    rdc(OFS_FL_STAT, 32'h1, 32'h1, "busy after go");
    wait_idle();
    chk(first_b, 8'h3c, "program starts at offset 0");
    chk(prog_bits, 32 + 8 * PAGE_BYTES, "one page programmed");
    rdc(OFS_EVT_STAT, 32'h1, 32'h1, "instruction done event");
    rdc(OFS_EVT_STAT, 32'h1, 32'h1, "event still pending");
    wr_reg(OFS_EVT_STAT, 32'h3);
    rdc(OFS_EVT_STAT, 32'h3, 32'h0, "events cleared");
    foreach (erase_ops[i])
    begin
      wr_reg(OFS_INS_CFG, {erase_ops[i], 24'h010000});
      wr_reg(OFS_INS_CMD, 32'h1);
      wait_idle();
      rdc(OFS_EVT_STAT, 32'h1, 32'h1, "erase done event");
      wr_reg(OFS_EVT_STAT, 32'h3);
    end
    $display("program and erase test done");
    wr_reg(OFS_INS_CFG, {OP_READ, 24'h0});
    wr_reg(OFS_INS_CMD, 32'h1);
    wait_idle();
    rdc(OFS_EVT_STAT, 32'h2, 32'h2, "page done event");
    for (int i = 0; i < PAGE_BYTES; i++)
      rdc(OFS_DATA_BASE + 12'(4 * i), 32'hff, 32'(i) ^ 32'ha5, "page byte");
    wr_reg(OFS_ACC_EN, 32'h0);
    chk(sel, 0, "flash handed back");
    wr_reg(OFS_INS_CMD, 32'h1);
    rdc(OFS_FL_STAT, 32'h3, 32'h0, "go refused");
    chk(fcs_b, 1, "flash left idle");
    $display("read and hand-back test done");
    print_verdict();
  end
endmodule : cfg_loader_tb
bind cfg_loader cfg_loader_checker u_cfg_loader_checker (.CORE_CLK_I, .RST_B_I, .ADDR_I, .WDATA_I, .WR_I,
  .RD_I, .RDATA_O, .TGT_PROG_B_O, .TGT_INIT_B_I, .TGT_DONE_I, .TGT_MODE_PS_O, .TGT_D_O, .TGT_CS_B_O,
  .TGT_CCLK_O, .DONE_LED_O, .FL_SEL_CTRL_O);

/* dv/flash_model.sv */
// behavioural serial flash: read pattern, busy status, program capture
`timescale 1ns/1ps
module flash_model
  import cfg_loader_pkg::*;
#(
  parameter int BUSY_POLLS = 3
)
(
  input wire logic sck_i, // serial clock
  input wire logic cs_b_i, // select, active low
  input wire logic mosi_i, // data from controller
  output logic miso_o, // data to controller
  output logic [7:0] prog_first_o, // first programmed byte
  output int prog_bits_o // bits of last program frame
);
  logic [31:0] hdr_q;
  logic [7:0] op_q;
  logic [7:0] out_b;
  int bit_q = 0;
  int busy_q = 0;
  initial miso_o = 1'b0;
  always @(posedge sck_i or posedge cs_b_i)
  begin
    if (cs_b_i)
    begin
      if (op_q == OP_PROG)
        prog_bits_o <= bit_q;
      // slow answer: erase and program stay busy for some polls
      if (op_q == OP_RDSR && busy_q > 0)
        busy_q <= busy_q - 1;
      else if (op_q == OP_PROG || op_q == OP_SECT_ERASE || op_q == OP_CHIP_ERASE)
        busy_q <= BUSY_POLLS;
      bit_q <= 0;
    end
    else
    begin
      hdr_q <= {hdr_q[30:0], mosi_i};
      if (bit_q == 7)
        op_q <= {hdr_q[6:0], mosi_i};
      if (bit_q == 39 && op_q == OP_PROG)
        prog_first_o <= {hdr_q[6:0], mosi_i};
      bit_q <= bit_q + 1;
    end
  end
  // released line toggles so a stale value is never mistaken for data
  always @(negedge sck_i or posedge cs_b_i)
  begin
    out_b = 8'((bit_q - 32) / 8) ^ 8'ha5;
    if (cs_b_i)
      miso_o <= ~miso_o;
    else if (op_q == OP_RDSR && bit_q >= 8)
      miso_o <= (bit_q % 8 == 7) && busy_q > 0;
    else if (op_q == OP_READ && bit_q >= 32)
      miso_o <= out_b[7 - bit_q % 8];
    else
      miso_o <= ~miso_o;
  end
endmodule : flash_model

/* rtl/cfg_loader.sv */
// register slave, target configuration port control and flash path mux
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
module cfg_loader
  import cfg_loader_pkg::*;
(
  input wire logic CORE_CLK_I, // core clock
  input wire logic RST_B_I, // async reset, active low
  input wire logic [cfg_loader_pkg::ADDR_W-1:0] ADDR_I, // register byte address
  input wire logic [31:0] WDATA_I, // write data
  input wire logic WR_I, // write strobe
  input wire logic RD_I, // read strobe
  output logic [31:0] RDATA_O, // read data, cycle after strobe
  output logic TGT_PROG_B_O, // target program, low holds it
  input wire logic TGT_INIT_B_I, // target init-ready pin
  input wire logic TGT_DONE_I, // target done pin
  output logic TGT_MODE_PS_O, // target mode pins, 1 parallel slave
  output logic [7:0] TGT_D_O, // parallel data to target
  output logic TGT_D_OE_O, // data pins drive enable
  output logic TGT_CS_B_O, // parallel chip select
  output logic TGT_CCLK_O, // configuration clock
  output logic DONE_LED_O, // done indicator
  output logic FL_SCK_O, // flash clock
  output logic FL_CS_B_O, // flash select
  output logic FL_MOSI_O, // flash data out
  input wire logic FL_MISO_I, // flash data in
  output logic FL_SEL_CTRL_O // 1 flash owned by controller
);
  import cfg_loader_pkg::*;
  typedef enum logic [1:0] {PS_IDLE, PS_LOW, PS_HIGH} ps_e;
  typedef struct packed {
    logic hold;
    logic mode;
    logic acc_en;
    logic [31:0] ins;
    logic go;
    logic ev_ins;
    logic ev_page;
    logic busy_d1;
    logic dbusy_d1;
    logic rd_buf;
    logic [31:0] rdata;
    ps_e ps;
    logic [7:0] pdata;
    logic pcs_b;
    logic pclk;
    logic doe;
    logic done_led;
    logic fl_sck;
    logic fl_cs_b;
    logic fl_mosi;
  } top_s;
  top_s q, d;
  logic [7:0] buf_rdata;
  logic fs_busy;
  logic fs_dbusy;
  logic fs_sck;
  logic fs_cs_b;
  logic fs_mosi;
  logic in_buf;
  logic buf_we;
  logic ps_wr;
  // aligned window compare, so no end-address sum that could wrap at the address width
  assign in_buf = (ADDR_I[ADDR_W-1:$clog2(4 * PAGE_BYTES)] == OFS_DATA_BASE[ADDR_W-1:$clog2(4 * PAGE_BYTES)]);
  assign buf_we = WR_I && in_buf && !fs_busy;
  assign ps_wr = WR_I && ADDR_I == OFS_PS_DATA && q.mode == MODE_PAR_SLAVE;
  flash_seq u_seq (
    .clk_i(CORE_CLK_I),
    .rst_b_i(RST_B_I),
    .go_i(q.go),
    .ins_i(q.ins),
    .buf_we_i(buf_we),
    .buf_addr_i(ADDR_I[9:2]),
    .buf_wdata_i(WDATA_I[7:0]),
    .buf_rdata_o(buf_rdata),
    .busy_o(fs_busy),
    .data_busy_o(fs_dbusy),
    .sck_o(fs_sck),
    .cs_b_o(fs_cs_b),
    .mosi_o(fs_mosi),
    .miso_i(FL_MISO_I)
  );
  always_comb
  begin
    d = q;
    d.go = 1'b0;
    d.busy_d1 = fs_busy;
    d.dbusy_d1 = fs_dbusy;
    d.done_led = TGT_DONE_I;
    d.rd_buf = RD_I && in_buf;
    d.rdata = 32'h0000_0000;
    if (q.busy_d1 && !fs_busy)
      d.ev_ins = 1'b1;
    if (q.dbusy_d1 && !fs_dbusy)
      d.ev_page = 1'b1;
    if (WR_I)
    begin
      unique case (ADDR_I)
        OFS_TGT_CTRL:
        begin
          d.hold = WDATA_I[BIT_HOLD];
          d.mode = WDATA_I[BIT_MODE];
        end
        OFS_ACC_EN:
          d.acc_en = WDATA_I[BIT_ACC_EN];
        OFS_INS_CFG:
          if (!fs_busy)
            d.ins = WDATA_I;
        OFS_INS_CMD:
          d.go = WDATA_I[BIT_GO] && !fs_busy && q.acc_en;
        OFS_EVT_STAT:
        begin
          // a new event in the clearing cycle wins
          if (WDATA_I[BIT_EV_INS] && !(q.busy_d1 && !fs_busy))
            d.ev_ins = 1'b0;
          if (WDATA_I[BIT_EV_PAGE] && !(q.dbusy_d1 && !fs_dbusy))
            d.ev_page = 1'b0;
        end
        default:
          d.go = 1'b0;
      endcase
    end
    if (RD_I && !in_buf)
    begin
      unique case (ADDR_I)
        OFS_TGT_CTRL:
        begin
          d.rdata[BIT_HOLD] = q.hold;
          d.rdata[BIT_MODE] = q.mode;
          d.rdata[BIT_INIT] = TGT_INIT_B_I;
          d.rdata[BIT_DONE] = TGT_DONE_I;
        end
        OFS_ACC_EN:
          d.rdata[BIT_ACC_EN] = q.acc_en;
        OFS_INS_CFG:
          d.rdata = q.ins;
        OFS_FL_STAT:
        begin
          d.rdata[BIT_INS_BUSY] = fs_busy;
          d.rdata[BIT_DATA_BUSY] = fs_dbusy;
        end
        OFS_EVT_STAT:
        begin
          d.rdata[BIT_EV_INS] = q.ev_ins;
          d.rdata[BIT_EV_PAGE] = q.ev_page;
        end
        default:
          d.rdata = 32'h0000_0000;
      endcase
    end
    // one data byte, one clock: low then high phase
    unique case (q.ps)
      PS_IDLE:
      begin
        d.pclk = 1'b0;
        d.pcs_b = 1'b1;
        if (ps_wr)
        begin
          d.pdata = WDATA_I[7:0];
          d.pcs_b = 1'b0;
          d.ps = PS_LOW;
        end
      end
      PS_LOW:
      begin
        d.pclk = 1'b1;
        d.ps = PS_HIGH;
      end
      PS_HIGH:
      begin
        d.pclk = 1'b0;
        d.pcs_b = 1'b1;
        d.ps = PS_IDLE;
      end
      default:
        d.ps = PS_IDLE;
    endcase
    // drive enable switches together with the mode pin
    d.doe = (d.mode == MODE_PAR_SLAVE);
    d.fl_sck = q.acc_en ? fs_sck : 1'b0;
    d.fl_cs_b = q.acc_en ? fs_cs_b : 1'b1;
    d.fl_mosi = fs_mosi;
  end
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      q <= '{hold: HOLD_RESET, mode: MODE_FLASH_MASTER, pcs_b: 1'b1, fl_cs_b: 1'b1, ps: PS_IDLE, default: '0};
    end
    else
    begin
      q <= d;
    end
  end
  // page buffer is read straight from the synchronous array
  assign RDATA_O = q.rd_buf ? {24'h00_0000, buf_rdata} : q.rdata;
  assign TGT_PROG_B_O = ~q.hold;
  assign TGT_MODE_PS_O = q.mode;
  assign TGT_D_O = q.pdata;
  assign TGT_D_OE_O = q.doe;
  assign TGT_CS_B_O = q.pcs_b;
  assign TGT_CCLK_O = q.pclk;
  assign DONE_LED_O = q.done_led;
  assign FL_SCK_O = q.fl_sck;
  assign FL_CS_B_O = q.fl_cs_b;
  assign FL_MOSI_O = q.fl_mosi;
  assign FL_SEL_CTRL_O = q.acc_en;
endmodule : cfg_loader

/* rtl/cfg_loader_pkg.sv */
// constants and register map of the target configuration and flash loader
package cfg_loader_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_TGT_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_ACC_EN = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_PS_DATA = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_INS_CFG = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_INS_CMD = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_FL_STAT = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_DATA_BASE = 12'h400;
  localparam int PAGE_BYTES = 256;
  // register bit fields: target control, access enable, command, status, events
  localparam int BIT_HOLD = 0;
  localparam int BIT_MODE = 1;
  localparam int BIT_INIT = 8;
  localparam int BIT_DONE = 9;
  localparam int BIT_ACC_EN = 0;
  localparam int BIT_GO = 0;
  localparam int BIT_INS_BUSY = 0;
  localparam int BIT_DATA_BUSY = 1;
  localparam int BIT_EV_INS = 0;
  localparam int BIT_EV_PAGE = 1;
  // instruction config: [31:24] flash opcode, [23:0] flash address
  localparam int INS_OP_LSB = 24;
  localparam logic MODE_FLASH_MASTER = 1'b0;
  localparam logic MODE_PAR_SLAVE = 1'b1;
  localparam logic HOLD_RESET = 1'b0;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SECT_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_RDSR = 8'h05;
  // serial flash clock: one enable per SCK_DIV core cycles
  localparam int SCK_DIV = 2;
endpackage : cfg_loader_pkg

/* rtl/flash_seq.sv */
// serial flash instruction sequencer with its own page buffer
`timescale 1ns/1ps
module flash_seq
  import cfg_loader_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic go_i,
  input wire logic [31:0] ins_i,
  input wire logic buf_we_i,
  input wire logic [7:0] buf_addr_i,
  input wire logic [7:0] buf_wdata_i,
  output logic [7:0] buf_rdata_o,
  output logic busy_o,
  output logic data_busy_o,
  output logic sck_o,
  output logic cs_b_o,
  output logic mosi_o,
  input wire logic miso_i
);
  typedef enum logic [2:0] {IDLE, WREN, GAP, SHIFT, POLL, PDONE} st_e;
  typedef struct packed {
    st_e st;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic [8:0] cnt;
    logic [8:0] nbytes;
    logic [1:0] div;
    logic [7:0] op;
    logic [23:0] addr;
    logic phase;
    logic sck;
    logic cs_b;
    logic data_busy;
  } fs_s;
  fs_s q, d;
  logic [7:0] mem [PAGE_BYTES];
  logic tick;
  logic [8:0] hdr;
  logic [8:0] idx;
  logic last_bit;
  logic wr_rd;
  assign tick = (q.div == 2'(SCK_DIV - 1));
  assign hdr = (q.op == OP_CHIP_ERASE || q.op == OP_WREN || q.op == OP_RDSR) ? 9'd1 : 9'd4;
  assign idx = q.cnt - hdr;
  assign last_bit = (q.bitn == 3'd7);
  assign wr_rd = tick && q.st == SHIFT && q.phase && last_bit && q.op == OP_READ && q.cnt >= hdr;
  always_comb
  begin
    d = q;
    d.div = tick ? 2'd0 : q.div + 2'd1;
    unique case (q.st)
      IDLE:
      begin
        if (go_i)
        begin
          d.op = ins_i[31:INS_OP_LSB];
          d.addr = ins_i[23:0];
          d.data_busy = (ins_i[31:INS_OP_LSB] == OP_READ || ins_i[31:INS_OP_LSB] == OP_PROG);
          d.st = (ins_i[31:INS_OP_LSB] == OP_READ) ? SHIFT : WREN;
          d.cnt = 9'd0;
          d.bitn = 3'd0;
          d.phase = 1'b0;
          d.cs_b = (ins_i[31:INS_OP_LSB] == OP_READ) ? 1'b0 : 1'b1;
          d.nbytes = (ins_i[31:INS_OP_LSB] == OP_CHIP_ERASE) ? 9'd1 :
            (ins_i[31:INS_OP_LSB] == OP_SECT_ERASE) ? 9'd4 : 9'd4 + 9'(PAGE_BYTES);
          d.sh = ins_i[31:INS_OP_LSB];
        end
      end
      WREN:
      begin
        // write enable latch must be set before program or erase
        d.st = GAP;
        d.op = OP_WREN;
        d.nbytes = 9'd1;
        d.sh = OP_WREN;
        d.cs_b = 1'b0;
        d.st = SHIFT;
      end
      SHIFT:
      begin
        if (tick)
        begin
          d.phase = ~q.phase;
          d.sck = ~q.phase;
          if (q.phase)
          begin
            d.sh = {q.sh[6:0], miso_i};
            d.bitn = q.bitn + 3'd1;
            if (last_bit)
            begin
              d.cnt = q.cnt + 9'd1;
              if (q.cnt + 9'd1 == q.nbytes)
              begin
                d.cs_b = 1'b1;
                d.st = GAP;
              end
              else if (q.cnt + 9'd1 < hdr)
                d.sh = q.addr[8'(23 - 8 * int'(q.cnt)) -: 8];
              else if (q.op == OP_PROG)
                d.sh = mem[8'(q.cnt + 9'd1 - hdr)];
              else
                d.sh = 8'h00;
            end
          end
        end
      end
      GAP:
      begin
        if (tick)
        begin
          d.cnt = 9'd0;
          d.bitn = 3'd0;
          d.cs_b = 1'b0;
          if (q.op == OP_WREN)
          begin
            d.op = ins_i[31:INS_OP_LSB];
            d.sh = ins_i[31:INS_OP_LSB];
            d.nbytes = (d.op == OP_CHIP_ERASE) ? 9'd1 : (d.op == OP_SECT_ERASE) ? 9'd4 : 9'd4 + 9'(PAGE_BYTES);
            d.st = SHIFT;
          end
          else if (q.op == OP_READ)
          begin
            d.cs_b = 1'b1;
            d.st = PDONE;
          end
          else
          begin
            d.op = OP_RDSR;
            d.sh = OP_RDSR;
            d.nbytes = 9'd2;
            d.st = POLL;
          end
        end
      end
      POLL:
      begin
        if (tick)
        begin
          d.phase = ~q.phase;
          d.sck = ~q.phase;
          if (q.phase)
          begin
            d.sh = {q.sh[6:0], miso_i};
            d.bitn = q.bitn + 3'd1;
            if (last_bit)
            begin
              d.cnt = q.cnt + 9'd1;
              d.sh = 8'h00;
              if (q.cnt == 9'd1)
              begin
                d.cs_b = 1'b1;
                // write-in-progress bit of the flash status byte
                d.st = miso_i ? GAP : PDONE;
              end
            end
          end
        end
      end
      PDONE:
      begin
        d.data_busy = 1'b0;
        d.st = IDLE;
      end
      default:
        d.st = IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      q <= '{st: IDLE, cs_b: 1'b1, default: '0};
    end
    else
    begin
      q <= d;
    end
  end
  // page buffer: host writes, read instruction fills it
  always_ff @(posedge clk_i)
  begin
    if (wr_rd)
      mem[idx[7:0]] <= {q.sh[6:0], miso_i};
    else if (buf_we_i)
      mem[buf_addr_i] <= buf_wdata_i;
    buf_rdata_o <= mem[buf_addr_i];
  end
  assign busy_o = (q.st != IDLE);
  assign data_busy_o = q.data_busy;
  assign sck_o = q.sck;
  assign cs_b_o = q.cs_b;
  assign mosi_o = q.sh[7];
endmodule : flash_seq
